/* core/fiac_ctrl.sv */
// Access control and write sequencing for in-application flash and
// data EEPROM programming. The cell arrays sit outside: this block
// issues single-byte program strobes to them and read strobes to the EEPROM.
// Assumes CPU requests are synchronous to core_clk and held stable
// while cpu_wait is high.
`timescale 1ns/1ps
module fiac_ctrl
	import fiac_pkg::*;
#(
	parameter int unsigned FLASH_WR_CYCLES = FLASH_WR_CYC,
	parameter int unsigned EE_WR_CYCLES    = EE_WR_CYC,
	parameter int unsigned WD1_CYCLES      = WD1_CYC,
	parameter int unsigned WD2_CYCLES      = WD2_CYC,
	parameter int unsigned WD3_CYCLES      = WD3_CYC
)
(
	input  wire logic         core_clk,
	input  wire logic         rst_n,
	input  wire logic         por_load,
	input  wire logic [7:0]   config_word_low,
	input  wire logic [7:0]   config_word_bandgap,
	input  wire logic         code_read_lock,
	input  wire fiac_sfr_type sfr,
	input  wire fiac_mem_type mem,
	input  wire logic         cell_done,
	output logic [7:0]        sfr_rdata,
	output logic              cpu_wait,
	output logic              access_denied,
	output logic              flash_prog,
	output logic              eeprom_prog,
	output logic              eeprom_rd,
	output logic [15:0]       cell_addr,
	output logic [7:0]        cell_wdata,
	output logic [7:0]        ctrl_low_q,
	output logic [7:0]        ctrl_bg_q
);

	fiac_state_type state_q, state_d;
	logic        unlock_q, unlock_d;
	logic        fwe_q, fwe_d;
	logic        ewe_q, ewe_d;
	logic        to_q, to_d;
	logic [7:0]  aux_q, aux_d;
	logic [7:0]  low_d, bg_d;
	logic [23:0] cnt_q, cnt_d;
	logic [23:0] wd_q, wd_d;
	logic        is_ee_op_q, is_ee_op_d;
	logic [7:0]  rdata_d;
	logic        wait_d, deny_d, fprog_d, eprog_d, erd_d;
	logic [15:0] caddr_d;
	logic [7:0]  cwdata_d;
	logic        is_flash, is_eeprom, code_ok, data_ok;
	logic        por_m_q, por_s_q;
	logic [1:0]  sel;
	logic [23:0] wd_limit;

	// Strap pulse passes two flops; only the second is read
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			por_m_q <= 1'b0;
			por_s_q <= 1'b0;
		end else begin
			por_m_q <= por_load;
			por_s_q <= por_m_q;
		end
	end

	fiac_region u_region (
		.addr             (mem.addr),
		.code_read_lock   (code_read_lock),
		.wide_unlock_flag (unlock_q),
		.is_flash         (is_flash),
		.is_eeprom        (is_eeprom),
		.code_ok          (code_ok),
		.data_ok          (data_ok)
	);

	assign sel = aux_q[BIT_SEL_LO +: 2];

	always_comb begin
		case (sel)
			2'b01:   wd_limit = 24'(WD1_CYCLES);
			2'b10:   wd_limit = 24'(WD2_CYCLES);
			2'b11:   wd_limit = 24'(WD3_CYCLES);
			default: wd_limit = 24'h000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Registers, write sequencer and read port
	always_comb begin
		state_d    = state_q;
		unlock_d   = unlock_q;
		fwe_d      = fwe_q;
		ewe_d      = ewe_q;
		to_d       = to_q;
		aux_d      = aux_q;
		low_d      = ctrl_low_q;
		bg_d       = ctrl_bg_q;
		cnt_d      = cnt_q;
		wd_d       = wd_q;
		is_ee_op_d = is_ee_op_q;
		wait_d     = cpu_wait;
		deny_d     = 1'b0;
		fprog_d    = 1'b0;
		eprog_d    = 1'b0;
		erd_d      = 1'b0;
		caddr_d    = cell_addr;
		cwdata_d   = cell_wdata;
		rdata_d    = 8'h00;

		if (sfr.wr) begin
			case (sfr.addr)
				ADDR_CMD: unlock_d = (sfr.wdata == CMD_UNLOCK);
				ADDR_WE: begin
					fwe_d = (sfr.wdata == CMD_FLASHWE);
					ewe_d = (sfr.wdata == CMD_EEPROM_WRITE_ENABLE);
				end
				ADDR_AUX: aux_d = sfr.wdata & AUX_MASK;
				ADDR_CW:  low_d = sfr.wdata;
				ADDR_BG:  bg_d  = sfr.wdata;
				default: ;
			endcase
		end
		if (sfr.rd) begin
			case (sfr.addr)
				ADDR_CMD: rdata_d[BIT_UNLOCK] = unlock_q;
				ADDR_WE: begin
					rdata_d[BIT_FWE] = fwe_q;
					rdata_d[BIT_TO]  = to_q;
					rdata_d[BIT_EWE] = ewe_q;
				end
				ADDR_AUX: rdata_d = aux_q;
				ADDR_CW:  rdata_d = ctrl_low_q;
				ADDR_BG:  rdata_d = ctrl_bg_q;
				default:  rdata_d = 8'h00;
			endcase
		end
		if (por_s_q) begin
			low_d = config_word_low;
			bg_d  = config_word_bandgap;
		end

		case (state_q)
			ST_IDLE: begin
				wait_d = 1'b0;
				if (mem.data_wr) begin
					caddr_d  = mem.addr;
					cwdata_d = mem.wdata;
					if (is_flash && fwe_q && data_ok) begin
						fprog_d    = 1'b1;
						wait_d     = 1'b1;
						is_ee_op_d = 1'b0;
						cnt_d      = 24'(FLASH_WR_CYCLES);
						wd_d       = 24'h000000;
						state_d    = ST_WRITE;
					end else if (is_eeprom && ewe_q) begin
						eprog_d    = 1'b1;
						wait_d     = 1'b1;
						is_ee_op_d = 1'b1;
						cnt_d      = 24'(EE_WR_CYCLES);
						wd_d       = 24'h000000;
						state_d    = ST_WRITE;
					end else begin
						deny_d = 1'b1;
					end
				end else if (mem.data_rd && is_eeprom) begin
					caddr_d = mem.addr;
					erd_d   = 1'b1;
					wait_d  = 1'b1;
					cnt_d   = 24'(EE_RD_CYC);
					state_d = ST_READ;
				end else if ((mem.data_rd && !data_ok
					&& (mem.addr <= CFG_HIGH))
					|| (mem.code_rd && !code_ok)) begin
					deny_d = 1'b1;
				end
				// Flash reads go straight to the array, no wait
			end
			ST_WRITE: begin
				cnt_d = (cnt_q != 24'h000000) ? cnt_q - 24'h000001 : cnt_q;
				wd_d  = wd_q + 24'h000001;
				if ((wd_limit != 24'h000000) && (wd_q >= wd_limit)) begin
					to_d    = 1'b1;
					wait_d  = 1'b0;
					state_d = ST_IDLE;
				// Ends on the count's last cycle or on cell_done: stall is at most the count
				end else if (cell_done || cnt_q <= 24'h000001) begin
					wait_d  = 1'b0;
					state_d = ST_IDLE;
				end
			end
			ST_READ: begin
				cnt_d = cnt_q - 24'h000001;
				if (cnt_q <= 24'h000001) begin
					wait_d  = 1'b0;
					state_d = ST_IDLE;
				end
			end
			default: begin
				wait_d  = 1'b0;
				state_d = ST_IDLE;
			end
		endcase

		// Timeout clears with its enable; a new timeout still wins
		if (!(is_ee_op_q ? ewe_d : fwe_d) && !(to_d && !to_q))
			to_d = 1'b0;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q       <= ST_IDLE;
			unlock_q      <= 1'b0;
			fwe_q         <= 1'b0;
			ewe_q         <= 1'b0;
			to_q          <= 1'b0;
			aux_q         <= AUX_RESET;
			ctrl_low_q    <= 8'h00;
			ctrl_bg_q     <= 8'h00;
			cnt_q         <= 24'h000000;
			wd_q          <= 24'h000000;
			is_ee_op_q    <= 1'b0;
			sfr_rdata     <= 8'h00;
			cpu_wait      <= 1'b0;
			access_denied <= 1'b0;
			flash_prog    <= 1'b0;
			eeprom_prog   <= 1'b0;
			eeprom_rd     <= 1'b0;
			cell_addr     <= 16'h0000;
			cell_wdata    <= 8'h00;
		end else begin
			state_q       <= state_d;
			unlock_q      <= unlock_d;
			fwe_q         <= fwe_d;
			ewe_q         <= ewe_d;
			to_q          <= to_d;
			aux_q         <= aux_d;
			ctrl_low_q    <= low_d;
			ctrl_bg_q     <= bg_d;
			cnt_q         <= cnt_d;
			wd_q          <= wd_d;
			is_ee_op_q    <= is_ee_op_d;
			sfr_rdata     <= rdata_d;
			cpu_wait      <= wait_d;
			access_denied <= deny_d;
			flash_prog    <= fprog_d;
			eeprom_prog   <= eprog_d;
			eeprom_rd     <= erd_d;
			cell_addr     <= caddr_d;
			cell_wdata    <= cwdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_flash_go;
		state_q == ST_IDLE && mem.data_wr && is_flash && fwe_q && data_ok;
	endsequence

	property p_unlock_set;
		@(posedge core_clk) disable iff (!rst_n)
		sfr.wr && sfr.addr == ADDR_CMD |=> unlock_q == $past(sfr.wdata == CMD_UNLOCK);
	endproperty
	a_unlock_set: assert property (p_unlock_set) else $error("unlock flag wrong");

	property p_we_cmd;
		@(posedge core_clk) disable iff (!rst_n)
		sfr.wr && sfr.addr == ADDR_WE && sfr.wdata == CMD_EEPROM_WRITE_ENABLE
			|=> ewe_q && !fwe_q;
	endproperty
	a_we_cmd: assert property (p_we_cmd) else $error("enable command wrong");

	property p_flash_stall;
		@(posedge core_clk) disable iff (!rst_n)
		s_flash_go |=> flash_prog && cpu_wait;
	endproperty
	a_flash_stall: assert property (p_flash_stall) else $error("no flash stall");

	property p_denied;
		@(posedge core_clk) disable iff (!rst_n)
		state_q == ST_IDLE && mem.data_wr && is_flash && !fwe_q
			|=> !flash_prog && !cpu_wait && access_denied;
	endproperty
	a_denied: assert property (p_denied) else $error("refused write acted");

	property p_rd_status;
		@(posedge core_clk) disable iff (!rst_n)
		sfr.rd && sfr.addr == ADDR_WE
			|=> sfr_rdata == {$past(fwe_q), $past(to_q), $past(ewe_q), 5'h00};
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status read wrong");

	property p_to_clear;
		@(posedge core_clk) disable iff (!rst_n)
		!fwe_q && !ewe_q && state_q == ST_IDLE |-> !to_q;
	endproperty
	a_to_clear: assert property (p_to_clear) else $error("timeout stuck");

	property p_cfg_top;
		@(posedge core_clk) disable iff (!rst_n)
		mem.data_wr && mem.addr == CFG_HIGH && state_q == ST_IDLE |=> !flash_prog;
	endproperty
	a_cfg_top: assert property (p_cfg_top) else $error("top config written");

	property p_ee_read;
		@(posedge core_clk) disable iff (!rst_n)
		$rose(eeprom_rd) |-> cpu_wait ##[1:8] !cpu_wait;
	endproperty
	a_ee_read: assert property (p_ee_read) else $error("EEPROM read too slow");

endmodule

/* core/fiac_pkg.sv */
// Constants and carrier types for the flash/EEPROM access controller.
// Assumes a 20 MHz core clock and an 8-bit special-register port.
package fiac_pkg;

	localparam int unsigned CLK_HZ = 20_000_000;

	localparam logic [7:0] ADDR_CMD = 8'h97;
	localparam logic [7:0] ADDR_WE  = 8'hc9;
	localparam logic [7:0] ADDR_BG  = 8'hf5;
	localparam logic [7:0] ADDR_CW  = 8'hf6;
	localparam logic [7:0] ADDR_AUX = 8'hf7;

	localparam logic [7:0] CMD_UNLOCK  = 8'h65;
	localparam logic [7:0] CMD_FLASHWE = 8'h47;
	localparam logic [7:0] CMD_EEPROM_WRITE_ENABLE   = 8'he2;

	localparam int BIT_UNLOCK = 0;
	localparam int BIT_FWE    = 7;
	localparam int BIT_TO     = 6;
	localparam int BIT_EWE    = 5;
	localparam int BIT_SEL_LO = 1;
	localparam int BIT_LOCK   = 1;
	localparam logic [7:0] AUX_RESET = 8'h06;
	localparam logic [7:0] AUX_MASK  = 8'hf7;

	localparam logic [15:0] LOCK_END   = 16'h01ff;
	localparam logic [15:0] WIDE_END   = 16'h3eff;
	localparam logic [15:0] FREE_END   = 16'h3fef;
	localparam logic [15:0] CFG_OPEN   = 16'h3ff7;
	localparam logic [15:0] CFG_HIGH   = 16'h3fff;
	localparam logic [15:0] EE_BASE    = 16'hee00;
	localparam logic [15:0] EE_LAST    = 16'heefe;

	// Times in microseconds (nanoseconds for the EEPROM read, tenths of a millisecond for the watchdog), cycles derived
	localparam int unsigned FLASH_WR_US  = 1000;
	localparam int unsigned EE_WR_US     = 2000;
	localparam int unsigned EE_RD_NS     = 300;
	localparam int unsigned WD1_TENTH_MS = 15;
	localparam int unsigned WD2_TENTH_MS = 58;
	localparam int unsigned WD3_TENTH_MS = 117;
	localparam int unsigned FLASH_WR_CYC = FLASH_WR_US * (CLK_HZ / 1_000_000);
	localparam int unsigned EE_WR_CYC    = EE_WR_US * (CLK_HZ / 1_000_000);
	localparam int unsigned EE_RD_CYC    =
		(EE_RD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned WD1_CYC = WD1_TENTH_MS * (CLK_HZ / 10_000);
	localparam int unsigned WD2_CYC = WD2_TENTH_MS * (CLK_HZ / 10_000);
	localparam int unsigned WD3_CYC = WD3_TENTH_MS * (CLK_HZ / 10_000);

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_WRITE = 2'b01,
		ST_READ  = 2'b10
	} fiac_state_type;

	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [7:0]  wdata;
	} fiac_sfr_type;

	typedef struct packed {
		logic        code_rd;
		logic        data_rd;
		logic        data_wr;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} fiac_mem_type;

endpackage

/* core/fiac_region.sv */
// Address decode of the flash and EEPROM windows against protection.
// Pure combinational; the caller registers the results.
`timescale 1ns/1ps
module fiac_region
	import fiac_pkg::*;
(
	input  wire logic [15:0] addr,
	input  wire logic        code_read_lock,
	input  wire logic        wide_unlock_flag,
	output logic             is_flash,
	output logic             is_eeprom,
	output logic             code_ok,
	output logic             data_ok
);

	always_comb begin
		is_flash  = (addr < CFG_HIGH);
		is_eeprom = (addr >= EE_BASE) && (addr <= EE_LAST) && !addr[0];
		code_ok   = 1'b0;
		data_ok   = 1'b0;
		if (addr <= LOCK_END) begin
			code_ok = !code_read_lock;
			data_ok = !code_read_lock && wide_unlock_flag;
		end else if (addr <= WIDE_END) begin
			code_ok = 1'b1;
			data_ok = wide_unlock_flag;
		end else if (addr <= FREE_END) begin
			code_ok = 1'b1;
			data_ok = 1'b1;
		end else if (addr <= CFG_OPEN) begin
			code_ok = 1'b1;
			data_ok = 1'b1;
		end else if (addr < CFG_HIGH) begin
			code_ok = 1'b1;
			data_ok = wide_unlock_flag;
		end else if (addr == CFG_HIGH) begin
			code_ok = 1'b1;
		end else begin
			data_ok = is_eeprom;
		end
	end

endmodule

/* tb/fiac_cpu_model.sv */
// CPU-side model issuing code reads, data reads and data writes.
// Assumes the controller answers one cycle after a taken request.
`timescale 1ns/1ps
module fiac_cpu_model
	import fiac_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       cpu_wait,
	input  wire logic [3:0] ans,
	output fiac_mem_type    mem
);
	initial begin
		mem = '0;
	end

	////////////////////////////////////////
	// k: 0 code read, 1 data read, 2 data write
	task automatic xfer(input int k, input logic [15:0] a,
		input logic [7:0] d, output logic [3:0] an, output int n);
		@(negedge core_clk);
		mem.code_rd = (k == 0);
		mem.data_rd = (k == 1);
		mem.data_wr = (k == 2);
		mem.addr = a;
		mem.wdata = d;
		@(negedge core_clk);
		an = ans;
		mem.code_rd = 1'b0;
		mem.data_rd = 1'b0;
		mem.data_wr = 1'b0;
		n = 0;
		// Address and data stay put for the whole stall
		while (cpu_wait === 1'b1 && n < 400) begin
			n++;
			@(negedge core_clk);
		end
		// Released lines show garbage, not the old value
		mem.addr = ~a;
		mem.wdata = ~d;
		@(negedge core_clk); // Idle slot before the next transfer
	endtask
endmodule

/* tb/fiac_ctrl_tb.sv */
// Self-checking bench for the flash and EEPROM access controller.
// Assumes short write and watchdog counts set through parameters.
`timescale 1ns/1ps
module fiac_ctrl_tb
	import fiac_pkg::*;
;
	localparam int FW = 20;
	localparam int EW = 40;
	localparam int W1 = 10;
	localparam int W2 = 30;
	localparam int W3 = 60;

	logic         core_clk;
	logic         rst_n;
	logic         por_load;
	logic         code_read_lock;
	logic         cell_done;
	logic [7:0]   cfg_lo;
	logic [7:0]   cfg_bg;
	fiac_sfr_type sfr;
	fiac_mem_type mem;
	logic [7:0]   sfr_rdata;
	logic         cpu_wait;
	logic         access_denied;
	logic         flash_prog;
	logic         eeprom_prog;
	logic         eeprom_rd;
	logic [15:0]  cell_addr;
	logic [7:0]   cell_wdata;
	logic [7:0]   ctrl_low_q;
	logic [7:0]   ctrl_bg_q;
	int           err_total = 0;
	int           checks = 0;
	int           w;

	initial core_clk = 1'b0;
	always #25 core_clk = ~core_clk;

	fiac_ctrl #(.FLASH_WR_CYCLES(FW), .EE_WR_CYCLES(EW),
		.WD1_CYCLES(W1), .WD2_CYCLES(W2), .WD3_CYCLES(W3)) u_dut (
		.core_clk(core_clk), .rst_n(rst_n), .por_load(por_load),
		.config_word_low(cfg_lo), .config_word_bandgap(cfg_bg),
		.code_read_lock(code_read_lock), .sfr(sfr), .mem(mem),
		.cell_done(cell_done), .sfr_rdata(sfr_rdata),
		.cpu_wait(cpu_wait), .access_denied(access_denied),
		.flash_prog(flash_prog), .eeprom_prog(eeprom_prog),
		.eeprom_rd(eeprom_rd), .cell_addr(cell_addr),
		.cell_wdata(cell_wdata), .ctrl_low_q(ctrl_low_q),
		.ctrl_bg_q(ctrl_bg_q));

	fiac_cpu_model u_cpu (.core_clk(core_clk), .cpu_wait(cpu_wait),
		.ans({flash_prog, eeprom_prog, eeprom_rd, access_denied}),
		.mem(mem));

	////////////////////////////////////////
	task automatic wrap_up();
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			err_total++;
		end
	endtask

	task automatic sw(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfr = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(negedge core_clk);
		sfr.wr = 1'b0;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(negedge core_clk);
		sfr = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(negedge core_clk);
		sfr.rd = 1'b0;
		chk({8'h00, sfr_rdata}, {8'h00, e});
	endtask

	// ew below zero: stall length judged by the caller
	task automatic mx(input int k, input logic [15:0] a,
		input logic [3:0] ea, input int ew);
		logic [3:0] an;
		int         n;
		u_cpu.xfer(k, a, a[7:0] ^ 8'h3c, an, n);
		w = n;
		if (n >= 400) begin
			err_total++;
			wrap_up();
		end else begin
			chk({12'h000, an}, {12'h000, ea});
			if (ew >= 0)
				chk(n[15:0], ew[15:0]);
			if (ea[3] | ea[2]) begin
				chk(cell_addr, a);
				chk({8'h00, cell_wdata}, {8'h00, a[7:0] ^ 8'h3c});
			end
		end
	endtask

	task automatic rg(input int k, input logic lk, input logic ul,
		input logic [15:0] a, input logic ok);
		sw(ADDR_CMD, ul ? CMD_UNLOCK : 8'h00);
		code_read_lock = lk;
		mx(k, a, ok ? (k == 2 ? 4'b1000 : 4'b0000) : 4'b0001,
			(ok && k == 2) ? FW : 0);
	endtask

	task automatic wd(input logic [1:0] s, input int lim);
		logic fto;
		logic eto;
		fto = lim > 0 && lim < FW;
		eto = lim > 0 && lim < EW;
		sw(ADDR_AUX, {5'h00, s, 1'b0});
		sw(ADDR_WE, CMD_FLASHWE);
		mx(2, 16'h3f20, 4'b1000, fto ? -1 : FW);
		if (fto)
			chk({15'h0, w >= lim - 1 && w <= lim + 1}, 16'h1);
		rchk(ADDR_WE, {1'b1, fto, 6'h00});
		sw(ADDR_WE, 8'h00);
		rchk(ADDR_WE, 8'h00);
		sw(ADDR_WE, CMD_EEPROM_WRITE_ENABLE);
		mx(2, EE_BASE, 4'b0100, eto ? -1 : EW);
		if (eto)
			chk({15'h0, w >= lim - 1 && w <= lim + 1}, 16'h1);
		rchk(ADDR_WE, {1'b0, eto, 1'b1, 5'h00});
		sw(ADDR_WE, 8'h00);
	endtask

	////////////////////////////////////////
	initial begin
		#(50 * 20000);
		err_total++;
		wrap_up();
	end

	initial begin
		rst_n = 1'b0;
		por_load = 1'b0;
		code_read_lock = 1'b0;
		cell_done = 1'b0;
		cfg_lo = 8'ha7;
		cfg_bg = 8'h5c;
		sfr = '0;
		repeat (5) @(negedge core_clk);
		rst_n = 1'b1;
		rchk(ADDR_WE, 8'h00);
		rchk(ADDR_CMD, 8'h00);
		rchk(ADDR_AUX, AUX_RESET);
		por_load = 1'b1;
		@(negedge core_clk);
		por_load = 1'b0;
		repeat (3) @(negedge core_clk);
		chk({8'h00, ctrl_low_q}, {8'h00, cfg_lo});
		chk({8'h00, ctrl_bg_q}, {8'h00, cfg_bg});
		sw(ADDR_CW, 8'h3b);
		chk({8'h00, ctrl_low_q}, 16'h003b);
		sw(ADDR_CMD, CMD_UNLOCK);
		rchk(ADDR_CMD, 8'h01);
		sw(ADDR_CMD, 8'h12);
		rchk(ADDR_CMD, 8'h00);
		sw(ADDR_WE, CMD_EEPROM_WRITE_ENABLE);
		rchk(ADDR_WE, 8'h20);
		sw(ADDR_WE, 8'h5a);
		rchk(ADDR_WE, 8'h00);
		sw(ADDR_WE, CMD_FLASHWE);
		rchk(ADDR_WE, 8'h80);
		rg(2, 0, 0, 16'h3f00, 1);
		rg(2, 0, 0, 16'h3fef, 1);
		rg(2, 0, 0, 16'h3eff, 0);
		rg(2, 0, 1, 16'h3eff, 1);
		rg(2, 0, 1, 16'h0200, 1);
		rg(2, 0, 0, 16'h0200, 0);
		rg(2, 1, 1, 16'h01ff, 0);
		rg(2, 0, 1, 16'h0000, 1);
		rg(2, 0, 0, 16'h0100, 0);
		rg(2, 0, 0, 16'h3ff7, 1);
		rg(2, 0, 0, 16'h3ff8, 0);
		rg(2, 0, 1, 16'h3ffe, 1);
		rg(2, 0, 1, 16'h3fff, 0);
		rg(0, 1, 1, 16'h0100, 0);
		rg(1, 1, 1, 16'h0100, 0);
		rg(0, 0, 0, 16'h0100, 1);
		rg(1, 0, 0, 16'h0100, 0);
		rg(0, 0, 0, 16'h3eff, 1);
		rg(0, 0, 0, 16'h3fff, 1);
		rg(1, 0, 0, 16'h3fff, 0);
		rg(1, 0, 1, 16'h2000, 1);
		rg(1, 0, 0, 16'h3f10, 1);
		cell_done = 1'b1;
		mx(2, 16'h3f30, 4'b1000, 1);
		cell_done = 1'b0;
		sw(ADDR_CMD, 8'h00);
		sw(ADDR_WE, 8'h00);
		mx(2, 16'h3f00, 4'b0001, 0);
		sw(ADDR_WE, CMD_EEPROM_WRITE_ENABLE);
		mx(2, 16'h3f00, 4'b0001, 0);
		mx(2, EE_BASE, 4'b0100, EW);
		mx(2, EE_LAST, 4'b0100, EW);
		mx(2, 16'hee01, 4'b0001, 0);
		mx(1, 16'hee02, 4'b0010, EE_RD_CYC);
		sw(ADDR_WE, CMD_FLASHWE);
		mx(2, EE_BASE, 4'b0001, 0);
		wd(2'b00, 0);
		wd(2'b01, W1);
		wd(2'b10, W2);
		wd(2'b11, W3);
		wrap_up();
	end
endmodule
